// ==== verilog/tsw_switch.sv ====
// pcm time slot switch: speech and connection memories, host port
//
// How it works
// - any of 256 inputs to any output
// - eight rx and tx lines at 2048 kbit/s
// - device clock 8192 or 4096 kHz selectable
// - bit 0 first, bit 7 last
// - frame sync pulse aligns frame timing
// - full input frame stored in arrival order
// - output counter walks connections, sends byte
// - entry index is output, content is input
// - select high indirect, low control or flags
// - accesses only while chip select low, but both strobes low resets without it
// - write captured at write strobe rise
// - each output line can float
// - clear writes float code, busy, bounded time
// - valid bit one floats slot when scheme 0
// - indirect access is control, data, address
// - standby floats all serial outputs immediately
`timescale 1ns/1ns
`default_nettype none
module tsw_switch #(
    parameter int CLEAR_LIMIT_CYC = tsw_pkg::CLEAR_LIMIT_CYC
) (
    input  wire logic       clk_sys_i,          // system clock, 125 MHz
    input  wire logic       nrst_i,             // async reset, active low
    input  wire logic       dev_clk_i,          // device clock pin
    input  wire logic       frame_sync_pulse_i, // frame sync, active high
    input  wire logic [7:0] pcm_rx_lines_i,     // serial inputs
    output logic      [7:0] pcm_tx_lines_o,     // serial outputs
    output logic      [7:0] pcm_tx_oe_o,        // serial output drive
    input  wire logic       cs_n_i,             // chip select, active low
    input  wire logic       rd_n_i,             // read strobe, active low
    input  wire logic       wr_n_i,             // write strobe, active low
    input  wire logic       register_select_i,  // 1 indirect, 0 control
    input  wire logic [7:0] host_data_bus_i,    // data bus in
    output logic      [7:0] host_data_bus_o,    // data bus out
    output logic            host_data_bus_oe_o  // data bus drive
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // pin synchronisers
    logic [21:0] sync_q;
    tsw_sync #(.W(22), .RST_VAL(tsw_pkg::SYNC_RST)) u_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .d_i       ({cs_n_i, rd_n_i, wr_n_i, register_select_i, dev_clk_i,
                     frame_sync_pulse_i, host_data_bus_i, pcm_rx_lines_i}),
        .q_o       (sync_q)
    );

    wire       cs_n_s = sync_q[21];
    wire       rd_n_s = sync_q[20];
    wire       wr_n_s = sync_q[19];
    wire       rs_s   = sync_q[18];
    wire       dclk_s = sync_q[17];
    wire       sp_s   = sync_q[16];
    wire [7:0] dat_s  = sync_q[15:8];
    wire [7:0] rx_s   = sync_q[7:0];

    logic                    rd_prev_reg;
    logic                    wr_prev_reg;
    logic                    dclk_prev_reg;
    logic                    sp_prev_reg;
    logic [7:0]              wdata_reg;
    logic [1:0]              ph_reg;
    logic [7:0]              bit_reg;
    logic [7:0]              mod_reg;
    logic [7:0]              cfg_reg;
    logic [1:0]              step_reg;
    logic [7:0]              ctl_reg;
    logic [7:0]              dat_reg;
    logic [7:0]              adr_reg;
    logic [9:0]              rb_reg;
    logic                    r_flag_reg;
    tsw_pkg::tsw_clr_state_t clr_state_reg;
    logic [7:0]              clr_idx_reg;
    logic [7:0]              rd_data_reg;
    logic                    rd_oe_reg;
    logic [15:0]             busy_cnt_reg;
    logic [7:0]              rx_sr_reg [tsw_pkg::LINES];
    logic [7:0]              sm_reg    [tsw_pkg::CM_DEPTH];
    logic [9:0]              cm_reg    [tsw_pkg::CM_DEPTH];
    logic [7:0]              rx_byte   [tsw_pkg::LINES];
    logic [9:0]              tx_ent    [tsw_pkg::LINES];
    logic [7:0]              tx_byte   [tsw_pkg::LINES];

    function automatic logic conn_valid(input logic [9:0] e, input logic te);
        conn_valid = te ? (e[8:0] != '0) : !e[tsw_pkg::CM_VALID];
    endfunction : conn_valid

    // host strobe decode
    wire sel     = !cs_n_s;
    wire sw_rst  = !wr_n_s && !rd_n_s;
    wire wr_rise = sel && wr_n_s && !wr_prev_reg && rd_n_s;
    wire rd_fall = sel && !rd_n_s && rd_prev_reg && wr_n_s;
    wire rd_rise = sel && rd_n_s && !rd_prev_reg && wr_n_s;
    wire mod_wr  = wr_rise && !rs_s;
    wire iar_wr  = wr_rise && rs_s;
    wire iar_rd  = rd_rise && rs_s;

    // frame timing
    wire       te        = mod_reg[tsw_pkg::MOD_TE];
    wire       sb        = mod_reg[tsw_pkg::MOD_SB];
    wire [1:0] ph_last   = cfg_reg[tsw_pkg::CFG_CPS] ? tsw_pkg::PH_LAST_FAST
                                                     : tsw_pkg::PH_LAST_SLOW;
    wire       dclk_rise = dclk_s && !dclk_prev_reg;
    wire       sp_rise   = sp_s && !sp_prev_reg;
    wire       bit_end   = dclk_rise && ph_reg == ph_last && !sp_rise;
    wire       sample    = dclk_rise && ph_reg == tsw_pkg::PH_SAMPLE && !sp_rise;
    wire       rx_done   = sample && bit_reg[2:0] == tsw_pkg::BIT_LAST;
    wire       tx_load   = sp_rise || (bit_end && bit_reg[2:0] == tsw_pkg::BIT_LAST);
    wire [4:0] tx_slot   = sp_rise ? '0 : bit_reg[7:3] + 5'h1;
    wire [7:0] rx_idx0   = {bit_reg[7:3], 3'h0};

    // indirect access decode
    wire       busy      = clr_state_reg == tsw_pkg::CLR_RUN;
    wire       clr_start = mod_wr && !wdata_reg[tsw_pkg::MOD_RC];
    wire       ind_rst   = mod_reg[tsw_pkg::MOD_RI] || clr_start || sw_rst;
    wire       exec      = iar_wr && step_reg == tsw_pkg::STEP_ADR;
    wire [1:0] k_f       = ctl_reg[tsw_pkg::K_HI:tsw_pkg::K_LO];
    wire [1:0] c_f       = ctl_reg[tsw_pkg::C_HI:tsw_pkg::C_LO];
    wire       cfr_hit   = exec && k_f == tsw_pkg::K_CFR && wdata_reg == tsw_pkg::CFR_IADDR;
    wire       cm_wr     = exec && !busy && (k_f == tsw_pkg::K_WRCM_A
                                          || k_f == tsw_pkg::K_WRCM_B);
    wire       cm_rd     = exec && k_f == tsw_pkg::K_RDCM;
    wire       cfr_wr    = cfr_hit && c_f == tsw_pkg::C_WRCFR;
    wire       cfr_rd    = cfr_hit && c_f == tsw_pkg::C_RDCFR;
    wire       clr_done  = busy && clr_idx_reg == tsw_pkg::CM_LAST;

    // read data selection
    wire [7:0] sta_val = (8'(busy) << tsw_pkg::STA_B)
                       | (8'(step_reg != tsw_pkg::STEP_CTL) << tsw_pkg::STA_Z)
                       | (8'(r_flag_reg) << tsw_pkg::STA_R);
    wire [7:0] iar_val = (step_reg == tsw_pkg::STEP_CTL) ? {ctl_reg[7:2], rb_reg[9:8]}
                       : (step_reg == tsw_pkg::STEP_DAT) ? rb_reg[7:0] : adr_reg;
    wire [7:0] rd_sel  = rs_s ? iar_val : sta_val;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_prev_reg   <= 1'b1;
            wr_prev_reg   <= 1'b1;
            dclk_prev_reg <= 1'b0;
            sp_prev_reg   <= 1'b0;
            wdata_reg     <= '0;
        end else begin
            rd_prev_reg   <= rd_n_s;
            wr_prev_reg   <= wr_n_s;
            dclk_prev_reg <= dclk_s;
            sp_prev_reg   <= sp_s;
            if (!wr_n_s) begin
                wdata_reg <= dat_s;
            end
        end
    end

    // bit phase and frame bit counter
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_reg  <= '0;
            bit_reg <= '0;
        end else if (sp_rise) begin
            ph_reg  <= '0;
            bit_reg <= '0;
        end else if (dclk_rise) begin
            if (ph_reg == ph_last) begin
                ph_reg  <= '0;
                bit_reg <= bit_reg + 8'h1;
            end else begin
                ph_reg <= ph_reg + 2'h1;
            end
        end
    end

    // receive shift, bit 0 arrives first
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int l = 0; l < tsw_pkg::LINES; l++) begin
                rx_sr_reg[l] <= '0;
            end
        end else if (sample) begin
            for (int l = 0; l < tsw_pkg::LINES; l++) begin
                rx_sr_reg[l] <= rx_byte[l];
            end
        end
    end

    // speech memory, fixed position per input slot and line
    always_ff @(posedge clk_sys_i) begin
        if (rx_done) begin
            for (int l = 0; l < tsw_pkg::LINES; l++) begin
                sm_reg[{bit_reg[7:3], 3'(l)}] <= rx_byte[l];
            end
        end
    end

    // connection memory: clear sweep or host write
    always_ff @(posedge clk_sys_i) begin
        if (busy) begin
            cm_reg[clr_idx_reg] <= tsw_pkg::CM_TRISTATE;
        end else if (cm_wr) begin
            cm_reg[wdata_reg] <= {c_f, dat_reg};
        end
    end

    generate
        for (genvar g = 0; g < tsw_pkg::LINES; g++) begin : g_line
            assign rx_byte[g] = {rx_s[g], rx_sr_reg[g][7:1]};
            assign tx_ent[g]  = cm_reg[{tx_slot, 3'(g)}];
            assign tx_byte[g] = sm_reg[tx_ent[g][7:0]];
            tsw_tx_lane u_lane (
                .clk_sys_i (clk_sys_i),
                .nrst_i    (nrst_i),
                .load_i    (tx_load),
                .byte_i    (tx_byte[g]),
                .en_i      (conn_valid(tx_ent[g], te)),
                .shift_i   (bit_end),
                .float_i   (sb),
                .tx_o      (pcm_tx_lines_o[g]),
                .oe_o      (pcm_tx_oe_o[g])
            );
        end
    endgenerate

    // host registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mod_reg <= tsw_pkg::MOD_RST;
            cfg_reg <= tsw_pkg::CFG_RST;
        end else if (sw_rst) begin
            mod_reg <= tsw_pkg::MOD_RST;
            cfg_reg <= tsw_pkg::CFG_RST;
        end else begin
            if (mod_wr) begin
                mod_reg <= wdata_reg;
            end
            if (cfr_wr) begin
                cfg_reg <= dat_reg;
            end
        end
    end

    // three-byte indirect sequence
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_reg <= tsw_pkg::STEP_CTL;
            ctl_reg  <= '0;
            dat_reg  <= '0;
            adr_reg  <= '0;
            rb_reg   <= '0;
        end else begin
            if (ind_rst) begin
                step_reg <= tsw_pkg::STEP_CTL;
            end else if (iar_wr || iar_rd) begin
                step_reg <= (step_reg == tsw_pkg::STEP_ADR) ? tsw_pkg::STEP_CTL
                                                            : step_reg + 2'h1;
            end
            if (iar_wr && !ind_rst) begin
                unique case (step_reg)
                    tsw_pkg::STEP_CTL: ctl_reg <= wdata_reg;
                    tsw_pkg::STEP_DAT: dat_reg <= wdata_reg;
                    default:           adr_reg <= wdata_reg;
                endcase
            end
            if (cm_rd) begin
                rb_reg <= cm_reg[wdata_reg];
            end else if (cfr_rd) begin
                rb_reg <= 10'(cfg_reg);
            end
        end
    end

    // connection memory clear sweep
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_state_reg <= tsw_pkg::CLR_IDLE;
            clr_idx_reg   <= '0;
            r_flag_reg    <= 1'b1;
        end else begin
            unique case (clr_state_reg)
                tsw_pkg::CLR_IDLE: begin
                    if (clr_start) begin
                        clr_state_reg <= tsw_pkg::CLR_RUN;
                        clr_idx_reg   <= '0;
                    end
                end
                tsw_pkg::CLR_RUN: begin
                    clr_idx_reg <= clr_idx_reg + 8'h1;
                    if (clr_done) begin
                        clr_state_reg <= tsw_pkg::CLR_IDLE;
                        r_flag_reg    <= 1'b0;
                    end
                end
                default: clr_state_reg <= tsw_pkg::CLR_IDLE;
            endcase
        end
    end

    // read drive, held while strobe and select stay low
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_reg <= '0;
            rd_oe_reg   <= 1'b0;
            busy_cnt_reg <= '0;
        end else begin
            if (rd_fall) begin
                rd_data_reg <= rd_sel;
            end
            rd_oe_reg    <= rd_fall || (rd_oe_reg && sel && !rd_n_s);
            busy_cnt_reg <= busy ? busy_cnt_reg + 16'h1 : '0;
        end
    end

    assign host_data_bus_o    = rd_data_reg;
    assign host_data_bus_oe_o = rd_oe_reg;

    a_frame_align: assert property (sp_rise |=> bit_reg == '0 && ph_reg == '0)
        else $error("frame counters not aligned to sync");
    a_rx_store: assert property (rx_done |=> sm_reg[$past(rx_idx0)] == $past(rx_byte[0]))
        else $error("received byte not stored at its slot");
    a_clear_busy: assert property ((clr_start && !busy) |=> busy [*8])
        else $error("busy not held after clear start");
    a_clear_bound: assert property (busy_cnt_reg < CLEAR_LIMIT_CYC)
        else $error("memory clear took too long");
    a_clear_code: assert property (busy |=> cm_reg[$past(clr_idx_reg)] == tsw_pkg::CM_TRISTATE)
        else $error("clear did not write float code");
    a_standby_float: assert property (sb |-> pcm_tx_oe_o == '0)
        else $error("output driven in standby");
    a_valid_flag: assert property ((tx_load && !te && tx_ent[0][9]) |=> !pcm_tx_oe_o[0])
        else $error("invalid connection drives its slot");
    a_tx_route: assert property ((tx_load && !sb) |=> pcm_tx_lines_o[0] == $past(tx_byte[0][0]))
        else $error("output slot not loaded from speech memory");
    a_mod_write: assert property (mod_wr |=> mod_reg == $past(wdata_reg))
        else $error("control register write lost");
    a_cs_gate: assert property (cs_n_s |=> !host_data_bus_oe_o)
        else $error("bus driven without chip select");
    a_rd_drive: assert property (rd_fall |=> host_data_bus_oe_o && host_data_bus_o == $past(rd_sel))
        else $error("read data not driven after strobe");
    a_ind_seq: assert property ((exec && !ind_rst) |=> step_reg == tsw_pkg::STEP_CTL)
        else $error("indirect sequence did not wrap");
endmodule : tsw_switch
`default_nettype wire

// ==== verilog/tsw_pkg.sv ====
// constants and types for the pcm time slot switch
package tsw_pkg;
    localparam int          LINES      = 8;
    localparam int          CM_DEPTH   = 256;
    // host register reset values
    localparam logic [7:0]  MOD_RST    = 8'hFF;
    localparam logic [7:0]  CFG_RST    = 8'hFF;
    // operating control register fields
    localparam int          MOD_RC     = 7;
    localparam int          MOD_TE     = 6;
    localparam int          MOD_RI     = 5;
    localparam int          MOD_SB     = 4;
    // configuration register field: 1 = 8192 kHz, 0 = 4096 kHz
    localparam int          CFG_CPS    = 0;
    // condition flags register fields
    localparam int          STA_B      = 7;
    localparam int          STA_Z      = 6;
    localparam int          STA_R      = 5;
    // connection entry
    localparam int          CM_VALID   = 9;
    localparam logic [9:0]  CM_TRISTATE = 10'h200;
    localparam logic [7:0]  CM_LAST    = 8'hFF;
    // indirect control byte
    localparam int          K_HI       = 5;
    localparam int          K_LO       = 4;
    localparam int          C_HI       = 1;
    localparam int          C_LO       = 0;
    localparam logic [1:0]  K_RDCM     = 2'h0;
    localparam logic [1:0]  K_WRCM_A   = 2'h2;
    localparam logic [1:0]  K_WRCM_B   = 2'h1;
    localparam logic [1:0]  K_CFR      = 2'h3;
    localparam logic [1:0]  C_WRCFR    = 2'h0;
    localparam logic [1:0]  C_RDCFR    = 2'h1;
    localparam logic [7:0]  CFR_IADDR  = 8'hFE;
    localparam logic [1:0]  STEP_CTL   = 2'h0;
    localparam logic [1:0]  STEP_DAT   = 2'h1;
    localparam logic [1:0]  STEP_ADR   = 2'h2;
    // line timing
    localparam int          DCLK_FAST_KHZ = 8192;
    localparam int          DCLK_SLOW_KHZ = 4096;
    localparam int          LINE_KBPS     = 2048;
    localparam logic [1:0]  PH_LAST_FAST  = 2'(DCLK_FAST_KHZ / LINE_KBPS - 1);
    localparam logic [1:0]  PH_LAST_SLOW  = 2'(DCLK_SLOW_KHZ / LINE_KBPS - 1);
    localparam logic [1:0]  PH_SAMPLE     = 2'h1;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    // memory clear time limit
    localparam int          CLK_KHZ         = 125000;
    localparam int          CLEAR_TIME_US   = 250;
    localparam int          CLEAR_LIMIT_CYC = CLEAR_TIME_US * CLK_KHZ / 1000;
    // synchroniser idle levels: strobes and chip select high
    localparam logic [21:0] SYNC_RST = 22'h380000;

    typedef enum logic [1:0] {
        CLR_IDLE = 2'b01,
        CLR_RUN  = 2'b10
    } tsw_clr_state_t;
endpackage : tsw_pkg

// ==== verilog/tsw_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module tsw_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys_i, // system clock
    input  wire logic         nrst_i,    // async reset, active low
    input  wire logic [W-1:0] d_i,       // asynchronous inputs
    output logic      [W-1:0] q_o        // synchronised copies
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule : tsw_sync
`default_nettype wire

// ==== verilog/tsw_tx_lane.sv ====
// one serial output line: slot shift register and drive enable
`timescale 1ns/1ns
`default_nettype none
module tsw_tx_lane (
    input  wire logic       clk_sys_i, // system clock
    input  wire logic       nrst_i,    // async reset, active low
    input  wire logic       load_i,    // slot start
    input  wire logic [7:0] byte_i,    // byte for the new slot
    input  wire logic       en_i,      // slot connection valid
    input  wire logic       shift_i,   // bit boundary
    input  wire logic       float_i,   // standby, force float
    output logic            tx_o,      // serial data
    output logic            oe_o       // line driven
);
    logic [7:0] sr_reg;
    logic       en_reg;

    // byte shifted right at each bit boundary, bit 0 first
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sr_reg <= '0;
            en_reg <= 1'b0;
        end else if (load_i) begin
            sr_reg <= byte_i;
            en_reg <= en_i;
        end else if (shift_i) begin
            sr_reg <= {1'b0, sr_reg[7:1]};
        end
    end

    assign tx_o = sr_reg[0];
    assign oe_o = en_reg && !float_i;
endmodule : tsw_tx_lane
`default_nettype wire

// ==== tb/tsw_far_end.sv ====
// far end model: device clock, frame sync and pcm line data
`timescale 1ns/1ns
`default_nettype none
module tsw_far_end (
    input  wire logic [2:0] per_bit_i, // device clocks a bit
    output logic            dev_clk_o, // device clock
    output logic            sync_o,    // frame sync
    output logic      [7:0] rx_o,      // line data
    output logic            mid_o,     // mid bit marker
    output logic      [7:0] pos_o      // bit in frame
);
    logic [7:0] tbl [256];
    logic [7:0] np;
    int         ph;
    initial begin
        dev_clk_o = 1'b0;
        sync_o    = 1'b0;
        rx_o      = 8'h00;
        mid_o     = 1'b0;
        pos_o     = 8'hFF;
        ph        = 0;
        #3;
        forever #32 dev_clk_o = ~dev_clk_o;
    end
    always @(negedge dev_clk_o) begin
        ph = (ph + 1 >= int'(per_bit_i)) ? 0 : ph + 1;
        mid_o  <= (ph == int'(per_bit_i) / 2);
        sync_o <= 1'b0;
        if (ph == 0) begin
            np = pos_o + 8'h01;
            pos_o  <= np;
            sync_o <= (np == 8'h00);
            for (int l = 0; l < 8; l++) begin
                rx_o[l] <= tbl[{np[7:3], 3'(l)}][np[2:0]];
            end
        end
    end
endmodule : tsw_far_end
`default_nettype wire

// ==== tb/tsw_switch_tb.sv ====
// self-checking bench for the pcm time slot switch
`timescale 1ns/1ns
`default_nettype none
module tsw_switch_tb;
    logic            clk_sys_i = 1'b0;
    logic            nrst_i = 1'b0;
    logic            cs_n_i = 1'b1;
    logic            rd_n_i = 1'b1;
    logic            wr_n_i = 1'b1;
    logic            register_select_i = 1'b0;
    logic      [7:0] host_data_bus_i = 8'h00;
    logic      [2:0] per_bit = 3'h4;
    wire logic       dev_clk, sync, mid, dout_oe;
    wire logic [7:0] rx, pos, tx, oe, dout;
    logic      [7:0] sm [256];
    logic      [9:0] cm [256];
    logic      [7:0] q;
    logic            te, sb;
    int              failures = 0;
    int              compares = 0;
    int              seed = 93;
    int              tries;

    always #4 clk_sys_i = ~clk_sys_i;

    tsw_far_end i_far (.per_bit_i(per_bit), .dev_clk_o(dev_clk), .sync_o(sync), .rx_o(rx),
        .mid_o(mid), .pos_o(pos));
    tsw_switch #(.CLEAR_LIMIT_CYC(300)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .dev_clk_i(dev_clk), .frame_sync_pulse_i(sync), .pcm_rx_lines_i(rx),
        .pcm_tx_lines_o(tx), .pcm_tx_oe_o(oe), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
        .wr_n_i(wr_n_i), .register_select_i(register_select_i),
        .host_data_bus_i(host_data_bus_i), .host_data_bus_o(dout),
        .host_data_bus_oe_o(dout_oe));

    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic give_up;
        failures++;
        final_report();
    endtask : give_up
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one host transfer, released bus shows inverted data
    task automatic acc(input logic rs, wr, nocs, input logic [7:0] d);
        @(negedge clk_sys_i);
        cs_n_i = nocs;
        register_select_i = rs;
        host_data_bus_i = d;
        wr_n_i = !wr;
        rd_n_i = wr;
        repeat (6) @(negedge clk_sys_i);
        q = dout;
        if (!wr && !nocs) cmp({15'h0, dout_oe}, 16'h1);
        wr_n_i = 1'b1;
        rd_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        cs_n_i = 1'b1;
        host_data_bus_i = ~d;
        repeat (4) @(negedge clk_sys_i);
        if (!wr) cmp({15'h0, dout_oe}, 16'h0);
    endtask : acc
    task automatic flags(input logic [7:0] e);
        acc(1'b0, 1'b0, 1'b0, 8'h00);
        cmp({8'h00, q}, {8'h00, e});
    endtask : flags
    task automatic set_mode(input logic [7:0] d);
        acc(1'b0, 1'b1, 1'b0, d);
        te = d[6];
        sb = d[4];
    endtask : set_mode
    task automatic ind(input logic [7:0] c, d, a);
        acc(1'b1, 1'b1, 1'b0, c);
        acc(1'b1, 1'b1, 1'b0, d);
        acc(1'b1, 1'b1, 1'b0, a);
    endtask : ind
    task automatic ind_rd(input logic [7:0] e1, e2);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        cmp({8'h00, q}, {8'h00, e1});
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        cmp({8'h00, q}, {8'h00, e2});
    endtask : ind_rd
    task automatic next_mid;
        int n;
        for (n = 0; n < 99 && mid === 1'b1; n++) @(negedge clk_sys_i);
        for (n = 0; n < 99 && mid !== 1'b1; n++) @(negedge clk_sys_i);
        if (n == 99) give_up();
    endtask : next_mid
    task automatic new_frame;
        next_mid();
        for (int k = 0; k < 300 && pos !== 8'h00; k++) next_mid();
        if (pos !== 8'h00) give_up();
    endtask : new_frame
    // compare both line vectors at mid bit, from the next slot start
    task automatic check_bits(input int n);
        logic [7:0] eo, et;
        logic [9:0] e;
        next_mid();
        for (int k = 0; k < 8 && pos[2:0] != 3'h0; k++) next_mid();
        for (int k = 0; k < n; k++) begin
            for (int l = 0; l < 8; l++) begin
                e = cm[{pos[7:3], 3'(l)}];
                eo[l] = !sb && (te ? e[8:0] != 9'h000 : !e[9]);
                et[l] = eo[l] && sm[e[7:0]][pos[2:0]];
            end
            cmp({oe, tx & oe}, {eo, et});
            next_mid();
        end
    endtask : check_bits

    initial begin
        for (int i = 0; i < 256; i++) begin
            sm[i] = 8'($random(seed));
            i_far.tbl[i] = sm[i];
        end
        te = 1'b1;
        sb = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        flags(8'h20);
        ind(8'h20, 8'h00, 8'h00);
        flags(8'h20);
        check_bits(32);
        new_frame();
        set_mode(8'h00);
        flags(8'hA0);
        for (tries = 0; tries < 25 && q[7] !== 1'b0; tries++) acc(1'b0, 1'b0, 1'b0, 8'h00);
        if (tries == 25) give_up();
        cmp({8'h00, q}, 16'h0000);
        for (int c = 0; c < 256; c++) cm[c] = 10'h200;
        check_bits(64);
        acc(1'b1, 1'b1, 1'b0, 8'h00);
        flags(8'h40);
        acc(1'b1, 1'b1, 1'b0, 8'h00);
        acc(1'b1, 1'b1, 1'b0, 8'h05);
        ind_rd(8'h00, 8'h05);
        set_mode(8'h80);
        for (int c = 0; c < 256; c++) begin
            cm[c] = 10'($random(seed));
            ind({2'b00, c[0] ? 2'b01 : 2'b10, 2'b00, cm[c][9:8]}, cm[c][7:0], 8'(c));
        end
        ind(8'h00, 8'h00, 8'h9C);
        ind_rd(cm[156][7:0], 8'h9C);
        check_bits(256);
        ind(8'h20, 8'h00, 8'h03);
        cm[3] = 10'h000;
        set_mode(8'hC0);
        check_bits(256);
        acc(1'b0, 1'b1, 1'b1, 8'hD0);
        check_bits(16);
        set_mode(8'hD0);
        check_bits(16);
        ind(8'h30, 8'h00, 8'hFE);
        ind(8'h31, 8'h00, 8'hFE);
        ind_rd(8'h00, 8'hFE);
        per_bit = 3'h2;
        set_mode(8'h80);
        new_frame();
        new_frame();
        check_bits(128);
        final_report();
    end
endmodule : tsw_switch_tb
`default_nettype wire
